// ===== bench/cesc_pd_model.sv
`timescale 1ns/1ns
// ==========
// Portable device on the data lines, seen through the comparators
module cesc_pd_model (
    input wire logic [11:0] dp_mv,
    input wire logic [11:0] dm_mv,
    input wire logic [11:0] thr_mv,
    output logic dp_above_th,
    output logic dp_above_floor,
    output logic dm_above_th
);
    assign dp_above_th = dp_mv > thr_mv;
    assign dp_above_floor = dp_mv > 12'h190;
    assign dm_above_th = dm_mv > thr_mv;
endmodule // cesc_pd_model

// ===== bench/cesc_stim_cfg_chk.sv
`timescale 1ns/1ns
`include "cesc_map.vh"
module cesc_stim_cfg_chk (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire bc12_profile,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire [2:0] first_step_divider_ratio,
    input wire threshold_used,
    input wire [2:0] response_class,
    input wire [3:0] second_step_response_select,
    input wire [3:0] second_step_response_magnitude,
    input wire divider_ratio_used
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_RATIO_RSVD: assert property (first_step_divider_ratio != 3'h7)
        else $error("ratio holds reserved code");
    AST_RATIO_HOLD: assert property (
        reg_wr && reg_addr == 8'h44 && bc12_profile && !$past(reg_wr)
        |-> ##2 first_step_divider_ratio == $past(first_step_divider_ratio, 2))
        else $error("ratio changed during bc12 profile");
    AST_DIV_USED: assert property (divider_ratio_used |-> response_class == `CESC_CLS_DIV)
        else $error("ratio used without divider");
    AST_DIV_BC12: assert property (divider_ratio_used |-> !$past(bc12_profile))
        else $error("ratio used during bc12 profile");
    AST_THR: assert property (
        reg_rvalid && $past(reg_rd) && $past(reg_addr) == 8'h45
        |-> threshold_used == (reg_rdata[2:0] != 3'h0 && reg_rdata[2:0] != 3'h7))
        else $error("threshold use wrong");
    AST_RESP_RB: assert property (
        reg_rvalid && $past(reg_rd) && $past(reg_addr) == 8'h46
        |-> {second_step_response_magnitude, second_step_response_select} == reg_rdata)
        else $error("response fields misplaced");
    AST_RSVD: assert property (
        !(second_step_response_select inside {4'h5, 4'h8, 4'hB}) && second_step_response_magnitude != 4'hF)
        else $error("reserved response accepted");
    AST_UNIMPL: assert property (
        reg_rvalid |-> !($past(reg_addr) == 8'h44 && reg_rdata[7:3] != 5'h00)
        && !($past(reg_addr) == 8'h45 && reg_rdata[7])) else $error("unimplemented bits read back");
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_CLASS: assert property (
        second_step_response_select inside {4'h6, 4'h9, 4'hC} ##1 $stable(second_step_response_select)
        |-> response_class == `CESC_CLS_DIV) else $error("divider class wrong");
    cover property (reg_rvalid);
    cover property (divider_ratio_used);
    cover property (threshold_used);
endmodule // cesc_stim_cfg_chk

bind cesc_stim_cfg cesc_stim_cfg_chk u_chk (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_rd, .bc12_profile,
    .reg_rdata, .reg_rvalid, .first_step_divider_ratio, .threshold_used, .response_class,
    .second_step_response_select, .second_step_response_magnitude, .divider_ratio_used);

// ===== bench/tb.sv
`timescale 1ns/1ns
`include "cesc_map.vh"
module tb;
    logic clk_sys = 0;
    logic rstn = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic bc12_profile = 0;
    logic vbus_ready = 0;
    logic vbus_present = 0;
    logic step_start = 0;
    logic [11:0] dp_mv = 12'h000;
    logic [11:0] dm_mv = 12'h000;
    wire dp_above_th, dp_above_floor, dm_above_th, reg_rvalid, ratio_valid, second_step_stimulus_seen;
    wire threshold_used, wait_removal, response_active, divider_ratio_used;
    wire [7:0] reg_rdata;
    wire [2:0] first_step_divider_ratio, response_class;
    wire [3:0] second_step_response_select, second_step_response_magnitude;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2 clk_sys = ~clk_sys;
    // Timer tick shrunk to 1 us: one timer unit is 250 cycles
    cesc_stim_cfg #(.TD_SCALE_US(1)) u_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .bc12_profile, .dp_above_th, .dp_above_floor, .dm_above_th, .vbus_ready, .vbus_present,
        .step_start, .reg_rdata, .reg_rvalid, .first_step_divider_ratio, .ratio_valid,
        .second_step_stimulus_seen, .threshold_used, .wait_removal, .response_active, .response_class,
        .second_step_response_select, .second_step_response_magnitude, .divider_ratio_used);
    cesc_pd_model u_pd (.dp_mv, .dm_mv, .thr_mv(12'h3E8), .dp_above_th, .dp_above_floor, .dm_above_th);
    // ==========
    // Access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk_sys);
        reg_rd = 0;
        chk({7'h00, reg_rvalid}, 8'h01, "read valid");
        chk(reg_rdata, exp, what);
    endtask
    function automatic logic [2:0] cls(input logic [3:0] s);
        case (s)
            4'h0: cls = `CESC_CLS_REMOVE;
            4'h1, 4'h2, 4'h3: cls = `CESC_CLS_VOLT;
            4'h6, 4'h9, 4'hC: cls = `CESC_CLS_DIV;
            4'hA: cls = `CESC_CLS_BRIDGE;
            default: cls = `CESC_CLS_RES;
        endcase
    endfunction
    task automatic stim(input logic [2:0] code, input logic [11:0] dp, input logic [11:0] dm,
        input logic vr, input logic vp, input logic exp);
        wr(8'h45, {5'h00, code});
        step_start = 1;
        dp_mv = dp;
        dm_mv = dm;
        vbus_ready = vr;
        vbus_present = vp;
        repeat (4) @(negedge clk_sys);
        chk({7'h00, second_step_stimulus_seen}, {7'h00, exp}, "stimulus seen");
        {step_start, vbus_ready, vbus_present} = 3'h0;
        dp_mv = 12'h000;
        dm_mv = 12'h000;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic delay_run(input logic [2:0] code, input int units);
        wr(8'h45, {2'h0, code, 3'h1});
        step_start = 1;
        dp_mv = 12'h4B0;
        repeat (units * `CESC_CLK_MHZ - 10) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h00, "delay early");
        repeat (20) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h01, "delay done");
        step_start = 0;
        dp_mv = 12'h000;
        repeat (4) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h00, "delay released");
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("ERROR %0t run did not finish", $time);
            end_of_test;
        end
    end
    // ==========
    // Tests
    initial begin
        logic [7:0] e;
        repeat (20) @(negedge clk_sys);
        rstn = 1;
        rd(8'h44, 8'h00, "ratio reset");
        rd(8'h45, 8'h00, "timing reset");
        rd(8'h46, 8'h00, "response reset");
        rd(8'h47, 8'h00, "unmapped");
        $display("Test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h44, 8'hF8 | c[7:0]);
            rd(8'h44, (c == 7) ? 8'h06 : c[7:0], "ratio");
            chk({5'h00, first_step_divider_ratio}, (c == 7) ? 8'h06 : c[7:0], "ratio out");
            chk({7'h00, ratio_valid}, 8'h01, "ratio valid");
        end
        bc12_profile = 1;
        wr(8'h44, 8'h02);
        rd(8'h44, 8'h06, "ratio frozen");
        bc12_profile = 0;
        $display("Test ratio done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h45, 8'hC0 | c[7:0]);
            e = (c == 4 || c == 5) ? 8'h43 : (8'h40 | c[7:0]);
            rd(8'h45, e, "timing");
            chk({6'h00, threshold_used, wait_removal}, (c == 0 || c == 7) ? 8'h00 : 8'h03, "threshold");
        end
        $display("Test timing done");
        e = 8'h00;
        for (int c = 0; c < 16; c++) begin
            wr(8'h46, {4'h3, c[3:0]});
            if (!(c inside {5, 8, 11})) e = {4'h3, c[3:0]};
            rd(8'h46, e, "response");
            chk({second_step_response_magnitude, second_step_response_select}, e, "response out");
            chk({5'h00, response_class}, {5'h00, cls(e[3:0])}, "class");
            chk({7'h00, divider_ratio_used}, {7'h00, cls(e[3:0]) == `CESC_CLS_DIV}, "ratio use");
        end
        wr(8'h46, 8'hF6);
        rd(8'h46, e, "magnitude reserved");
        wr(8'h46, 8'h36);
        bc12_profile = 1;
        repeat (2) @(negedge clk_sys);
        chk({7'h00, divider_ratio_used}, 8'h00, "ratio unused in bc12");
        bc12_profile = 0;
        repeat (2) @(negedge clk_sys);
        chk({7'h00, divider_ratio_used}, 8'h01, "ratio used again");
        $display("Test response done");
        stim(3'h1, 12'h4B0, 12'h000, 0, 0, 1);
        stim(3'h6, 12'h4B0, 12'h000, 0, 0, 1);
        stim(3'h3, 12'h000, 12'h4B0, 0, 0, 1);
        stim(3'h3, 12'h4B0, 12'h000, 0, 0, 0);
        stim(3'h2, 12'h258, 12'h000, 0, 0, 1);
        stim(3'h2, 12'h12C, 12'h000, 0, 0, 0);
        stim(3'h2, 12'h4B0, 12'h000, 0, 0, 0);
        stim(3'h0, 12'h000, 12'h000, 1, 0, 1);
        stim(3'h7, 12'h000, 12'h000, 0, 1, 1);
        $display("Test stimulus done");
        wr(8'h46, 8'h11);
        for (int c = 1; c < 4; c++) begin
            delay_run(c[2:0], (c == 1) ? 1 : (c == 2) ? 5 : 10);
        end
        wr(8'h45, 8'h49);
        step_start = 1;
        dp_mv = 12'h4B0;
        repeat (3) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h01, "hold start");
        dp_mv = 12'h000;
        repeat (230) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h01, "hold kept");
        repeat (30) @(negedge clk_sys);
        chk({7'h00, response_active}, 8'h00, "hold ended");
        step_start = 0;
        $display("Test timer done");
        end_of_test;
    end
endmodule // tb

// ===== hw/cesc_map.vh
`ifndef CESC_MAP_VH
`define CESC_MAP_VH
// ==========================================
// Register offsets
`define CESC_ADDR_S1_RATIO 8'h44
`define CESC_ADDR_S2_TIMING 8'h45
`define CESC_ADDR_S2_RESP 8'h46
`define CESC_REG_RESET 8'h00
// ==========================================
// Field positions
`define CESC_RATIO_MSB 2
`define CESC_TYPE_BIT 6
`define CESC_TD_MSB 5
`define CESC_TD_LSB 3
`define CESC_STIM_MSB 2
`define CESC_MAG_MSB 7
`define CESC_MAG_LSB 4
`define CESC_RSEL_MSB 3
// ==========================================
// Codes
`define CESC_RATIO_RSVD 3'h7
`define CESC_STIM_VBUS_READY 3'h0
`define CESC_STIM_DP_ABOVE 3'h1
`define CESC_STIM_DP_WINDOW 3'h2
`define CESC_STIM_DM_ABOVE 3'h3
`define CESC_STIM_RSVD_A 3'h4
`define CESC_STIM_RSVD_B 3'h5
`define CESC_STIM_DP_ABOVE_ALT 3'h6
`define CESC_STIM_VBUS_PRESENT 3'h7
`define CESC_MAG_RSVD 4'hF
`define CESC_RSP_REMOVE 4'h0
`define CESC_RSP_VOLT_DP 4'h1
`define CESC_RSP_VOLT_DM 4'h2
`define CESC_RSP_VOLT_BOTH 4'h3
`define CESC_RSP_RES_DP 4'h4
`define CESC_RSP_RSVD_5 4'h5
`define CESC_RSP_DIV_DP 4'h6
`define CESC_RSP_RES_DM 4'h7
`define CESC_RSP_RSVD_8 4'h8
`define CESC_RSP_DIV_DM 4'h9
`define CESC_RSP_BRIDGE 4'hA
`define CESC_RSP_RSVD_B 4'hB
`define CESC_RSP_DIV_BOTH 4'hC
`define CESC_RSP_RES_BOTH 4'hD
// ==========================================
// Response classes
`define CESC_CLS_REMOVE 3'h0
`define CESC_CLS_VOLT 3'h1
`define CESC_CLS_RES 3'h2
`define CESC_CLS_DIV 3'h3
`define CESC_CLS_BRIDGE 3'h4
`define CESC_CLS_NONE 3'h7
// ==========================================
// Timer lengths in ticks, one per timer code
`define CESC_TD_MS_0 7'h00
`define CESC_TD_MS_1 7'h01
`define CESC_TD_MS_5 7'h05
`define CESC_TD_MS_10 7'h0A
`define CESC_TD_MS_20 7'h14
`define CESC_TD_MS_40 7'h28
`define CESC_TD_MS_80 7'h50
`define CESC_TD_MS_100 7'h64
// ==========================================
// Timing: base tick is 1 ms
`define CESC_CLK_MHZ 250
`define CESC_TICK_US 1000
`endif

// ===== hw/cesc_reg_mem.v
`timescale 1ns/1ns
// ==========================================
// Four-entry register store, registered read data
module cesc_reg_mem #(
    parameter AW = 2,
    parameter DW = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire wr_en,
    input wire [AW-1:0] wr_idx,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_idx,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];
    integer i;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_q[i] <= {DW{1'b0}};
            end
            rd_data <= {DW{1'b0}};
        end else begin
            if (wr_en) begin
                mem_q[wr_idx] <= wr_data;
            end
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule // cesc_reg_mem

// ===== hw/cesc_stim_cfg.v
`timescale 1ns/1ns
`include "cesc_map.vh"
// Functional notes
// - Ratio codes 0..6 decoded, 7 reserved
// - Ratio applies only to divider responses
// - CDP/DCP profile freezes ratio control
// - Type one: hold response for timer
// - Type zero: timer delays the response
// - Timer codes 0,1,5,10,20,40,80,100 ms
// - Code 000 VBUS ready, no removal wait
// - Codes 001/110 D+ above, 011 D- above
// - Code 010 D+ window, 400 mV floor
// - Code 111 VBUS present; 100/101 reserved
// - Magnitude bits 7-4, selection bits 3-0
// - Reserved code write rejected, value kept
// - Voltage magnitude decode, 1111 reserved
// - Resistor magnitude decode, 1111 reserved
// - Divider magnitude decode, 1111 reserved
// - Response selection decoded to actions
// - Threshold ignored for stimulus 000/111
module cesc_stim_cfg #(
    parameter TD_SCALE_US = `CESC_TICK_US
) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire bc12_profile,
    input wire dp_above_th,
    input wire dp_above_floor,
    input wire dm_above_th,
    input wire vbus_ready,
    input wire vbus_present,
    input wire step_start,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg [2:0] first_step_divider_ratio,
    output reg ratio_valid,
    output reg second_step_stimulus_seen,
    output reg threshold_used,
    output reg wait_removal,
    output reg response_active,
    output reg [2:0] response_class,
    output reg [3:0] second_step_response_select,
    output reg [3:0] second_step_response_magnitude,
    output reg divider_ratio_used
);
    // ==========================================
    // Timer constants
    localparam [31:0] TICK_CYC = `CESC_CLK_MHZ * TD_SCALE_US;
    // Step timer states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_HOLD = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;

    // ==========================================
    // Register write filter
    reg [2:0] ratio_q;
    reg type_q;
    reg [2:0] td_q;
    reg [2:0] stim_q;
    reg [3:0] mag_q;
    reg [3:0] rsel_q;
    wire [3:0] w_mag = reg_wdata[`CESC_MAG_MSB:`CESC_MAG_LSB];
    wire [3:0] w_rsel = reg_wdata[`CESC_RSEL_MSB:0];
    wire w_rsel_rsvd = (w_rsel == `CESC_RSP_RSVD_5) || (w_rsel == `CESC_RSP_RSVD_8) ||
        (w_rsel == `CESC_RSP_RSVD_B);
    wire w_mag_rsvd = (w_mag == `CESC_MAG_RSVD);
    wire w_ratio_rsvd = (reg_wdata[`CESC_RATIO_MSB:0] == `CESC_RATIO_RSVD);
    wire w_stim_rsvd = (reg_wdata[`CESC_STIM_MSB:0] == `CESC_STIM_RSVD_A) ||
        (reg_wdata[`CESC_STIM_MSB:0] == `CESC_STIM_RSVD_B);
    // Ratio belongs to legacy profiles, so a BC1.2 profile freezes it
    wire wr_ratio = reg_wr && (reg_addr == `CESC_ADDR_S1_RATIO) && !bc12_profile;
    wire acc_ratio = wr_ratio && !w_ratio_rsvd;
    wire acc_timing = reg_wr && (reg_addr == `CESC_ADDR_S2_TIMING) && !w_stim_rsvd;
    wire acc_resp = reg_wr && (reg_addr == `CESC_ADDR_S2_RESP) && !w_rsel_rsvd && !w_mag_rsvd;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ratio_q <= 3'h0;
            type_q <= 1'b0;
            td_q <= 3'h0;
            stim_q <= 3'h0;
            mag_q <= 4'h0;
            rsel_q <= 4'h0;
        end else if (reg_wr) begin
            // Reserved codes leave the old setting alone
            if (acc_ratio) begin
                ratio_q <= reg_wdata[`CESC_RATIO_MSB:0];
            end
            if (acc_timing) begin
                type_q <= reg_wdata[`CESC_TYPE_BIT];
                td_q <= reg_wdata[`CESC_TD_MSB:`CESC_TD_LSB];
                stim_q <= reg_wdata[`CESC_STIM_MSB:0];
            end
            if (acc_resp) begin
                mag_q <= w_mag;
                rsel_q <= w_rsel;
            end
        end
    end

    // ==========================================
    // Register store mirror; reads use the direct path below
    reg [1:0] rd_idx;
    wire [7:0] mem_rdata;

    // Entry 3 is never written, so unmapped offsets find zero there
    always @* begin
        case (reg_addr)
            `CESC_ADDR_S1_RATIO: rd_idx = 2'h0;
            `CESC_ADDR_S2_TIMING: rd_idx = 2'h1;
            `CESC_ADDR_S2_RESP: rd_idx = 2'h2;
            default: rd_idx = 2'h3;
        endcase
    end

    // ==========================================
    // Store mirrors live fields, so it always holds accepted values
    reg [1:0] mirror_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mirror_q <= 2'h0;
        end else begin
            mirror_q <= (mirror_q == 2'h2) ? 2'h0 : mirror_q + 2'h1;
        end
    end

    wire [7:0] mirror_data = (mirror_q == 2'h0) ? {5'h00, ratio_q} :
        (mirror_q == 2'h1) ? {1'b0, type_q, td_q, stim_q} : {mag_q, rsel_q};

    cesc_reg_mem #(.AW(2), .DW(8)) u_mem (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(1'b1),
        .wr_idx(mirror_q),
        .wr_data(mirror_data),
        .rd_idx(rd_idx),
        .rd_data(mem_rdata)
    );

    // Direct read path avoids mirror lag of up to three cycles
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= `CESC_REG_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `CESC_ADDR_S1_RATIO: reg_rdata <= {5'h00, ratio_q};
                    `CESC_ADDR_S2_TIMING: reg_rdata <= {1'b0, type_q, td_q, stim_q};
                    `CESC_ADDR_S2_RESP: reg_rdata <= {mag_q, rsel_q};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================
    // Stimulus detection
    reg stim_hit;
    always @* begin
        case (stim_q)
            `CESC_STIM_VBUS_READY: stim_hit = vbus_ready;
            `CESC_STIM_DP_ABOVE: stim_hit = dp_above_th;
            `CESC_STIM_DP_ABOVE_ALT: stim_hit = dp_above_th;
            `CESC_STIM_DM_ABOVE: stim_hit = dm_above_th;
            // Lower edge is the fixed 400 mV floor, on D+ only
            `CESC_STIM_DP_WINDOW: stim_hit = !dp_above_th && dp_above_floor;
            `CESC_STIM_VBUS_PRESENT: stim_hit = vbus_present;
            default: stim_hit = 1'b0;
        endcase
    end
    wire vbus_stim = (stim_q == `CESC_STIM_VBUS_READY) || (stim_q == `CESC_STIM_VBUS_PRESENT);

    // ==========================================
    // Timer: 1 ms tick enable and ms count
    reg [31:0] tick_cnt_q;
    reg tick_q;
    reg [6:0] ms_q;
    reg [6:0] td_ms;
    reg [1:0] st_q;
    reg [1:0] st_d;

    always @* begin
        case (td_q)
            3'h0: td_ms = `CESC_TD_MS_0;
            3'h1: td_ms = `CESC_TD_MS_1;
            3'h2: td_ms = `CESC_TD_MS_5;
            3'h3: td_ms = `CESC_TD_MS_10;
            3'h4: td_ms = `CESC_TD_MS_20;
            3'h5: td_ms = `CESC_TD_MS_40;
            3'h6: td_ms = `CESC_TD_MS_80;
            default: td_ms = `CESC_TD_MS_100;
        endcase
    end
    wire timer_done = (ms_q >= td_ms);
    // Counter rests in IDLE so a new step starts on a whole tick;
    // the first tick can thus come up to one clock late, never early

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_CYC - 32'h1);
            tick_cnt_q <= (st_q == ST_IDLE || tick_cnt_q == TICK_CYC - 32'h1) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // ==========================================
    // Step state machine
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (step_start && stim_hit) begin
                    st_d = type_q ? ST_HOLD : ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (timer_done) begin
                    st_d = ST_DONE;
                end
            end
            ST_HOLD: begin
                // Response outlives the timer while the stimulus persists
                if (timer_done && !stim_hit) begin
                    st_d = ST_IDLE;
                end
            end
            ST_DONE: begin
                // Delayed response stays until the step is disarmed
                if (!step_start) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            ms_q <= 7'h00;
        end else begin
            st_q <= st_d;
            // Every state change restarts the count
            if (st_d != st_q) begin
                ms_q <= 7'h00;
            end else if (tick_q && !timer_done) begin
                ms_q <= ms_q + 7'h01;
            end
        end
    end

    // ==========================================
    // Response decode
    reg [2:0] cls;
    always @* begin
        case (rsel_q)
            `CESC_RSP_REMOVE: cls = `CESC_CLS_REMOVE;
            `CESC_RSP_VOLT_DP, `CESC_RSP_VOLT_DM, `CESC_RSP_VOLT_BOTH: cls = `CESC_CLS_VOLT;
            `CESC_RSP_RES_DP, `CESC_RSP_RES_DM, `CESC_RSP_RES_BOTH: cls = `CESC_CLS_RES;
            // Both extend the resistor set after 1101
            4'hE, 4'hF: cls = `CESC_CLS_RES;
            `CESC_RSP_DIV_DP, `CESC_RSP_DIV_DM, `CESC_RSP_DIV_BOTH: cls = `CESC_CLS_DIV;
            `CESC_RSP_BRIDGE: cls = `CESC_CLS_BRIDGE;
            default: cls = `CESC_CLS_NONE;
        endcase
    end

    // ==========================================
    // Registered outputs, one cycle behind the stored fields, except response_active, which is taken from st_d and tracks st_q
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            first_step_divider_ratio <= 3'h0;
            ratio_valid <= 1'b0;
            second_step_stimulus_seen <= 1'b0;
            threshold_used <= 1'b0;
            wait_removal <= 1'b0;
            response_active <= 1'b0;
            response_class <= `CESC_CLS_REMOVE;
            second_step_response_select <= 4'h0;
            second_step_response_magnitude <= 4'h0;
            divider_ratio_used <= 1'b0;
        end else begin
            first_step_divider_ratio <= ratio_q;
            ratio_valid <= (ratio_q != `CESC_RATIO_RSVD);
            second_step_stimulus_seen <= stim_hit;
            threshold_used <= !vbus_stim;
            wait_removal <= !vbus_stim;
            response_active <= (st_d == ST_HOLD) || (st_d == ST_DONE);
            response_class <= cls;
            second_step_response_select <= rsel_q;
            second_step_response_magnitude <= mag_q;
            divider_ratio_used <= (cls == `CESC_CLS_DIV) && !bc12_profile;
        end
    end
endmodule // cesc_stim_cfg
